// ### verilog/sram_ctl_params.svh
// Constants for the synchronous pipelined memory bus-side control block
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define SRAM_ADDR_W 8
`define SRAM_DATA_W 32
`define SRAM_LANES  4
`define SRAM_LANE_W 8
`define SRAM_DEPTH  256

`endif

// ### verilog/sram_ctl_pkg.sv
// Types shared by the memory control block
package sram_ctl_pkg;
  // Output bus driver state
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,  // Bus released, nothing pending
    BUS_READ  = 2'b01,  // Read data in output register
    BUS_WRHZ  = 2'b10,  // High-Z held after a write
    BUS_SLEEP = 2'b11   // Low-power mode
  } bus_state_e;
endpackage

// ### verilog/sram_core.sv
// Memory array with byte-lane writes and a registered read port
`timescale 1ns/100ps
`include "sram_ctl_params.svh"

module sram_core (
  input  wire logic                      clk_sys,  // System clock
  input  wire logic                      wr_en,    // Write strobe
  input  wire logic [`SRAM_LANES-1:0]    wr_lane,  // Lanes to write
  input  wire logic [`SRAM_ADDR_W-1:0]   wr_addr,  // Write address
  input  wire logic [`SRAM_DATA_W-1:0]   wr_data,  // Write data
  input  wire logic                      rd_en,    // Read strobe
  input  wire logic [`SRAM_ADDR_W-1:0]   rd_addr,  // Read address
  output logic      [`SRAM_DATA_W-1:0]   rd_data   // Read data, one cycle later
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [`SRAM_DATA_W-1:0] mem [0:`SRAM_DEPTH-1];  // No reset: contents undefined at power-up

  // Byte-lane write
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      for (int i = 0; i < `SRAM_LANES; i++) begin
        if (wr_lane[i]) begin
          mem[wr_addr][i*`SRAM_LANE_W +: `SRAM_LANE_W] <= wr_data[i*`SRAM_LANE_W +: `SRAM_LANE_W];
        end
      end
    end
  end

  // Array read, registered
  always_ff @(posedge clk_sys) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### verilog/sync_sram_bus_control.sv
// Bus-side control of a pipelined synchronous memory: select, writes, output bus, sleep
`timescale 1ns/100ps
`include "sram_ctl_params.svh"

// What this block does
// - Selected only if a, c low, b high
// - Full write: global low, or master, lanes low
// - Bus stays high-Z after write until strobe read
// - Data pins high-Z when leaving sleep
module sync_sram_bus_control (
  input  wire logic                      clk_sys,              // System clock, 25 MHz
  input  wire logic                      rst_n,                // Synchronous reset, active low
  input  wire logic [`SRAM_ADDR_W-1:0]   addr,                 // Address pins
  input  wire logic                      select_enable_a_n,    // First enable, active low
  input  wire logic                      select_enable_b,      // Second enable, active high
  input  wire logic                      select_enable_c_n,    // Third enable, active low
  input  wire logic                      proc_addr_strobe_n,   // Processor address strobe
  input  wire logic                      ctrl_addr_strobe_n,   // Controller address strobe
  input  wire logic                      global_write_n,       // Global write, active low
  input  wire logic                      byte_write_master_n,  // Byte-write enable, active low
  input  wire logic [`SRAM_LANES-1:0]    lane_write_sel_n,     // Byte-lane selects, active low
  input  wire logic                      out_enable_n,         // Output enable, active low
  input  wire logic                      sleep_req,            // Sleep input, active high
  input  wire logic [`SRAM_DATA_W-1:0]   dq_in,                // Data pins, input side
  output logic      [`SRAM_DATA_W-1:0]   dq_out,               // Data pins, output side
  output logic                           dq_oe,                // Data pins drive enable, high drives
  output logic                           sleep_active          // Low-power mode indication
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`SRAM_ADDR_W-1:0] addr_m, addr_s;          // Address stages
  logic [2:0]              en_m, en_s;              // Enable stages
  logic [1:0]              stb_m, stb_s;            // Strobe stages
  logic                    gw_m, gw_s;              // Global write stages
  logic                    bwe_m, bwe_s;            // Byte-write master stages
  logic [`SRAM_LANES-1:0]  lane_m, lane_s;          // Lane select stages
  logic                    oe_m, oe_s;              // Output enable stages
  logic                    zz_m, zz_s;              // Sleep stages
  logic [`SRAM_DATA_W-1:0] din_m, din_s;            // Data stages

  // Two flops on every pin; all stages move together so a cycle stays coherent
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      addr_m <= '0;
      addr_s <= '0;
      en_m   <= 3'b101;
      en_s   <= 3'b101;
      stb_m  <= 2'b11;
      stb_s  <= 2'b11;
      gw_m   <= 1'b1;
      gw_s   <= 1'b1;
      bwe_m  <= 1'b1;
      bwe_s  <= 1'b1;
      lane_m <= '1;
      lane_s <= '1;
      oe_m   <= 1'b1;
      oe_s   <= 1'b1;
      zz_m   <= 1'b0;
      zz_s   <= 1'b0;
      din_m  <= '0;
      din_s  <= '0;
    end else begin
      addr_m <= addr;
      addr_s <= addr_m;
      en_m   <= {select_enable_a_n, select_enable_b, select_enable_c_n};
      en_s   <= en_m;
      stb_m  <= {proc_addr_strobe_n, ctrl_addr_strobe_n};
      stb_s  <= stb_m;
      gw_m   <= global_write_n;
      gw_s   <= gw_m;
      bwe_m  <= byte_write_master_n;
      bwe_s  <= bwe_m;
      lane_m <= lane_write_sel_n;
      lane_s <= lane_m;
      oe_m   <= out_enable_n;
      oe_s   <= oe_m;
      zz_m   <= sleep_req;
      zz_s   <= zz_m;
      din_m  <= dq_in;
      din_s  <= din_m;
    end
  end

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Combined select from the three enables
  function automatic logic chip_sel(input logic [2:0] en);
    chip_sel = (en == 3'b010);
  endfunction

  // Lanes to write; all lanes for a full-width request
  function automatic logic [`SRAM_LANES-1:0] lanes_of(input logic gw_n, input logic bwe_n,
                                                      input logic [`SRAM_LANES-1:0] sel_n);
    if (!gw_n) begin
      lanes_of = '1;
    end else if (!bwe_n) begin
      lanes_of = ~sel_n;
    end else begin
      lanes_of = '0;
    end
  endfunction

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  logic                    selected;       // Enables say selected
  logic                    strobe;         // Either strobe low
  logic                    addr_take;      // New access registered
  logic [`SRAM_LANES-1:0]  lanes;          // Decoded lanes
  logic                    is_write;       // Write in this cycle
  logic                    is_read;        // Read started in this cycle
  logic                    desel_take;     // Strobe seen while deselected

  assign selected  = chip_sel(en_s);
  assign strobe    = ~stb_s[1] | ~stb_s[0];
  assign addr_take = strobe & selected & ~sleep_active;
  assign lanes     = lanes_of(gw_s, bwe_s, lane_s);
  // Processor strobe starts a read even with write lines active
  assign is_write  = addr_take & stb_s[1] & (lanes != '0);
  assign is_read   = addr_take & ~is_write;
  // A strobe with any other enable pattern is a deselect cycle: drop off the shared bus
  assign desel_take = strobe & ~selected;

  // ----------------------------------------
  // Memory
  // ----------------------------------------
  logic [`SRAM_DATA_W-1:0] rd_word;        // Array output

  sram_core u_core (
    .clk_sys (clk_sys),
    .wr_en   (is_write),
    .wr_lane (lanes),
    .wr_addr (addr_s),
    .wr_data (din_s),
    .rd_en   (is_read),
    .rd_addr (addr_s),
    .rd_data (rd_word)
  );

  // ----------------------------------------
  // Output pipeline and bus state
  // ----------------------------------------
  sram_ctl_pkg::bus_state_e state_reg;     // Driver state
  logic                     rd_pend_reg;   // Array read one cycle old

  // Read pending marker
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= is_read;
    end
  end

  // Driver state machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= sram_ctl_pkg::BUS_IDLE;
    end else begin
      case (state_reg)
        sram_ctl_pkg::BUS_SLEEP: begin
          if (!zz_s) begin
            state_reg <= sram_ctl_pkg::BUS_IDLE;
          end
        end
        default: begin
          // Sleep honoured only when deselected; host must deselect first
          if (zz_s && !selected) begin
            state_reg <= sram_ctl_pkg::BUS_SLEEP;
          end else if (is_write) begin
            state_reg <= sram_ctl_pkg::BUS_WRHZ;
          end else if (desel_take) begin
            state_reg <= sram_ctl_pkg::BUS_IDLE;
          end else if (rd_pend_reg) begin
            state_reg <= sram_ctl_pkg::BUS_READ;
          end
        end
      endcase
    end
  end

  // Output data register, loaded from the array one cycle after the read
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dq_out <= '0;
    end else if (rd_pend_reg) begin
      dq_out <= rd_word;
    end
  end

  // Drive only with read data present and output enable low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dq_oe <= 1'b0;
    end else if (zz_s || state_reg == sram_ctl_pkg::BUS_SLEEP) begin
      dq_oe <= 1'b0;
    end else if (is_write) begin
      dq_oe <= 1'b0;
    end else if (desel_take) begin
      dq_oe <= 1'b0;
    end else if (rd_pend_reg) begin
      dq_oe <= ~oe_s;
    end else if (state_reg == sram_ctl_pkg::BUS_READ) begin
      dq_oe <= ~oe_s;
    end else begin
      dq_oe <= 1'b0;
    end
  end

  // Sleep indication
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sleep_active <= 1'b0;
    end else if (zz_s && !selected) begin
      sleep_active <= 1'b1;
    end else if (!zz_s) begin
      sleep_active <= 1'b0;
    end
  end

endmodule

// ### dv/sync_sram_bus_control_properties.sv
// Port-level timing properties of the memory bus control block
`timescale 1ns/100ps
module sync_sram_bus_control_properties (
  input wire logic        clk_sys,              // Clock
  input wire logic        rst_n,                // Reset, active low
  input wire logic [7:0]  addr,                 // Address
  input wire logic        select_enable_a_n,    // Enable a
  input wire logic        select_enable_b,      // Enable b
  input wire logic        select_enable_c_n,    // Enable c
  input wire logic        proc_addr_strobe_n,   // Processor strobe
  input wire logic        ctrl_addr_strobe_n,   // Controller strobe
  input wire logic        global_write_n,       // Global write
  input wire logic        byte_write_master_n,  // Byte-write enable
  input wire logic [3:0]  lane_write_sel_n,     // Lane selects
  input wire logic        out_enable_n,         // Output enable
  input wire logic        sleep_req,            // Sleep request
  input wire logic [31:0] dq_in,                // Data in
  input wire logic [31:0] dq_out,               // Data out
  input wire logic        dq_oe,                // Drive enable
  input wire logic        sleep_active          // Sleep state
);
  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  wire sel = !select_enable_a_n && select_enable_b && !select_enable_c_n;  // Selected
  wire idl = proc_addr_strobe_n && ctrl_addr_strobe_n;                     // No strobe
  wire rd  = sel && !idl && (!proc_addr_strobe_n || (global_write_n && byte_write_master_n));  // Read
  // Full-width write only, so byte-lane subsets never trigger
  wire wr  = sel && proc_addr_strobe_n && !ctrl_addr_strobe_n
             && (!global_write_n || (!byte_write_master_n && lane_write_sel_n == 4'h0));
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  read_drive_a: assert property (rd && !out_enable_n && !sleep_active && !sleep_req ##1
    (idl && !out_enable_n && !sleep_req) [*4] |-> ##[0:1] dq_oe) else $error("read did not drive bus");
  desel_ignore_a: assert property ((!idl && !sel) ##1 idl [*4] |-> !dq_oe)
    else $error("deselected strobe drove bus");
  write_hiz_a: assert property (idl [*4] ##1 wr ##1 idl [*6] |-> !dq_oe)
    else $error("bus driven after write");
  sleep_enter_a: assert property ((sleep_req && !sel) [*4] |-> sleep_active)
    else $error("sleep not entered");
  sleep_hiz_a: assert property (sleep_active |-> !dq_oe) else $error("bus driven in sleep");
  sleep_exit_a: assert property ($fell(sleep_active) |-> !dq_oe [*2]) else $error("bus driven at wake");
  wake_time_a: assert property (!sleep_req [*4] |-> !sleep_active) else $error("sleep held too long");
  out_hold_a: assert property (idl [*6] |-> $stable(dq_out)) else $error("read data moved");
  oe_block_a: assert property (out_enable_n [*4] |-> !dq_oe) else $error("bus driven with enable high");
endmodule

// ### dv/sram_host.sv
// Host-side bus model driving the memory's control, address and data pins
`timescale 1ns/100ps
module sram_host (
  input  wire logic        clk_sys,  // Clock
  output logic      [10:0] ctl,      // Enables, strobes, writes, lanes
  output logic      [7:0]  addr,     // Address
  output logic      [31:0] dq,       // Write data
  output logic             slp,      // Sleep request
  output logic             oe_n      // Output enable, active low
);
  localparam logic [10:0] IDLE = 11'h2ff;  // Selected, no strobe
  initial begin
    ctl = IDLE;
    addr = 8'h00;
    dq = 32'h0000_0000;
    slp = 1'b0;
    oe_n = 1'b0;
  end
  // Output enable is a level; changed just after an edge like every other pin
  task automatic set_oe_n(input logic v);
    @(posedge clk_sys);
    #1;
    oe_n = v;
  endtask
  // One request cycle; afterwards the released data lines show the inverse
  task automatic access(input logic [10:0] c, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    ctl = c;
    addr = a;
    dq = d;
    @(posedge clk_sys);
    #1;
    ctl = IDLE;
    dq = ~d;
  endtask
  // Deselect a cycle ahead so the sleep request never meets a selected device
  task automatic sleep_mode(input logic on);
    @(posedge clk_sys);
    #1;
    ctl = 11'h6ff;
    @(posedge clk_sys);
    #1;
    slp = on;
  endtask
endmodule

// ### dv/sync_sram_bus_control_tb.sv
// Self-checking bench for the memory bus control block
`timescale 1ns/100ps
module sync_sram_bus_control_tb;
  logic        clk_sys = 1'b0;  // 25 MHz clock
  logic        rst_n = 1'b0;    // Reset, active low
  logic [10:0] ctl;             // Host control bundle
  logic [7:0]  addr;            // Address
  logic [31:0] dq_in;           // Write data
  logic        sleep_req;       // Sleep
  logic        out_enable_n;    // Output enable, active low
  logic [31:0] dq_out;          // Read data
  logic        dq_oe;           // Drive enable
  logic        sleep_active;    // Sleep state
  int          err_total = 0;   // Mismatches
  int          n_compared = 0;  // Comparisons
  localparam logic [10:0] RD_P = 11'h27f;  // Processor-strobe read
  localparam logic [10:0] RD_C = 11'h2bf;  // Controller-strobe read
  localparam logic [10:0] WR_G = 11'h29f;  // Global write
  localparam logic [10:0] WR_B = 11'h2a0;  // Byte-write, all lanes
  localparam logic [10:0] WR_L0 = 11'h2ae; // Byte-write, lane 0 only
  always #20 clk_sys = ~clk_sys;
  sram_host host (.clk_sys(clk_sys), .ctl(ctl), .addr(addr), .dq(dq_in), .slp(sleep_req), .oe_n(out_enable_n));
  sync_sram_bus_control DUT (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .select_enable_a_n(ctl[10]),
    .select_enable_b(ctl[9]), .select_enable_c_n(ctl[8]), .proc_addr_strobe_n(ctl[7]),
    .ctrl_addr_strobe_n(ctl[6]), .global_write_n(ctl[5]), .byte_write_master_n(ctl[4]),
    .lane_write_sel_n(ctl[3:0]), .out_enable_n(out_enable_n), .sleep_req(sleep_req), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .sleep_active(sleep_active));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Answer lands after the fourth edge past the request
  task automatic rd_chk(input logic [10:0] c, input logic [7:0] a, input logic [31:0] exp, input logic oe);
    host.access(c, a, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("dq_oe", dq_oe, oe);
    if (oe) chk("dq_out", dq_out, exp);
  endtask
  task automatic wr_chk(input logic [10:0] c, input logic [7:0] a, input logic [31:0] d);
    host.access(c, a, d);
    repeat (5) @(posedge clk_sys);
    #1;
    chk("dq_oe after write", dq_oe, 0);
  endtask
  task automatic t_writes();
    wr_chk(WR_G, 8'h05, 32'ha5a5_0f0f);
    wr_chk(WR_B, 8'h06, 32'h1234_5678);
    rd_chk(RD_P, 8'h05, 32'ha5a5_0f0f, 1'b1);
    rd_chk(RD_C, 8'h06, 32'h1234_5678, 1'b1);
    wr_chk(WR_L0, 8'h05, 32'hffff_ffc3);
    rd_chk(RD_P, 8'h05, 32'ha5a5_0fc3, 1'b1);
  endtask
  // Every enable combination but one must leave the bus released
  task automatic t_deselect();
    wr_chk(WR_G, 8'h07, 32'h0bad_f00d);
    rd_chk(RD_P, 8'h07, 32'h0bad_f00d, 1'b1);
    for (int i = 0; i < 8; i++) begin
      if (i != 2) rd_chk({i[2:0], 8'h7f}, 8'h07, 32'h0000_0000, 1'b0);
    end
    rd_chk(RD_P, 8'h07, 32'h0bad_f00d, 1'b1);
  endtask
  task automatic t_sleep();
    host.sleep_mode(1'b1);
    repeat (4) @(posedge clk_sys);
    #1;
    chk("sleep_active", sleep_active, 1);
    rd_chk(RD_P, 8'h05, 32'h0000_0000, 1'b0);
    host.sleep_mode(1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("sleep exit", sleep_active, 0);
    chk("dq_oe at wake", dq_oe, 0);
    rd_chk(RD_P, 8'h06, 32'h1234_5678, 1'b1);
  endtask
  // Output enable high keeps the bus released even with read data waiting
  task automatic t_oe();
    host.set_oe_n(1'b1);
    rd_chk(RD_P, 8'h05, 32'ha5a5_0fc3, 1'b0);
    host.set_oe_n(1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("dq_oe on enable", dq_oe, 1);
    chk("dq_out on enable", dq_out, 32'ha5a5_0fc3);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge clk_sys);
    t_writes();
    t_deselect();
    t_sleep();
    t_oe();
    final_report();
  end
  // Hang guard
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
bind sync_sram_bus_control sync_sram_bus_control_properties u_prop (.clk_sys(clk_sys), .rst_n(rst_n),
  .addr(addr), .select_enable_a_n(select_enable_a_n), .select_enable_b(select_enable_b),
  .select_enable_c_n(select_enable_c_n), .proc_addr_strobe_n(proc_addr_strobe_n),
  .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .global_write_n(global_write_n),
  .byte_write_master_n(byte_write_master_n), .lane_write_sel_n(lane_write_sel_n),
  .out_enable_n(out_enable_n), .sleep_req(sleep_req), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .sleep_active(sleep_active));
